// ===== rtl/rgw_pkg.sv
// package: constants and carrier types of the reset generator and wake-up sequencer
package rgw_pkg;
  localparam int CLK_MHZ = 50;
  localparam int PIN_LOW_CYC = 128;
  localparam int SAMPLE_WAIT_CYC = 64;
  localparam int SEQ_CYC = 192;
  localparam int SYNC_EXTRA_CYC = 3;
  localparam int CHECK_WINDOWS = 50;
  localparam logic [7:0] WD_KEY1 = 8'h55;
  localparam logic [7:0] WD_KEY2 = 8'haa;
  localparam int CNT_W = 8;
  localparam int WD_W = 16;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_INTEN = 4'h1;
  localparam logic [3:0] ADDR_FLAGS = 4'h2;
  localparam logic [3:0] ADDR_WDCTL = 4'h3;
  localparam logic [3:0] ADDR_WDARM = 4'h4;
  localparam logic [3:0] ADDR_RTICTL = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;

  localparam int CTRL_PLL_CLOCK_SELECT_BIT = 0;
  localparam int CTRL_CME_BIT = 1;
  localparam int CTRL_SELF_CLOCK_ENABLE_BIT = 2;
  localparam int CTRL_PSTOP_BIT = 3;
  localparam int CTRL_PRE_BIT = 4;
  localparam logic [7:0] CTRL_RESET = 8'h06;
  localparam int WDCTL_WIN_BIT = 7;
  localparam logic [7:0] WDCTL_RESET = 8'h00;
  localparam logic [7:0] RTICTL_RESET = 8'h00;
  localparam logic [2:0] INTEN_RESET = 3'h0;

  typedef enum logic [1:0] {
    VEC_POR_EXT,
    VEC_CLKMON,
    VEC_WATCHDOG
  } rgw_vec_t;

  typedef struct packed {
    logic powerOn;
    logic lowVoltage;
    logic lossOfClock;
    logic pllLock;
    logic clockOk;
  } rgw_status_in_t;

  typedef struct packed {
    logic periodic;
    logic lock;
    logic selfClock;
  } rgw_irq_t;
endpackage

// ===== rtl/rgw_edge_flag.sv
// sticky flag set by hardware event, cleared by writing one
`timescale 1ns/1ns
`default_nettype none
module rgw_edge_flag (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic setEvt,
  input wire logic clrWr,
  input wire logic enable,
  output logic flag,
  output logic irq
);
  logic flag_ff;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flag_ff <= 1'b0;
    end else if (setEvt) begin
      // set wins over a simultaneous clear so no event is lost
      flag_ff <= 1'b1;
    end else if (clrWr) begin
      flag_ff <= 1'b0;
    end
  end
  assign flag = flag_ff;
  assign irq = flag_ff & enable;
endmodule // rgw_edge_flag
`default_nettype wire

// ===== rtl/rgw_counter.sv
// loadable down counter with zero indication
`timescale 1ns/1ns
`default_nettype none
module rgw_counter #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  input wire logic run,
  output logic [W-1:0] count,
  output logic zero
);
  logic [W-1:0] cnt_ff;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else if (load) begin
      cnt_ff <= loadVal;
    end else if (run && cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end
  assign count = cnt_ff;
  assign zero = (cnt_ff == '0);
endmodule // rgw_counter
`default_nettype wire

// ===== rtl/rgw_reset_wakeup.sv
// reset generator, wake-up sequencer, watchdog and interrupt flags
`timescale 1ns/1ns
`default_nettype none
module rgw_reset_wakeup (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire rgw_pkg::rgw_status_in_t statusIn,
  input wire logic stopReq,
  input wire logic wakeIrq,
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe,
  output logic internalReset,
  output rgw_pkg::rgw_vec_t resetVector,
  output logic vectorValid,
  output logic clocksStopped,
  output logic selfClockMode,
  output logic pllClockSelect,
  output logic clockMonitorActive,
  output rgw_pkg::rgw_irq_t irqReq
);
  typedef enum logic [2:0] {
    ST_RUN,
    ST_STOP,
    ST_CHECK,
    ST_PINLOW,
    ST_WAIT,
    ST_HOLD
  } rgw_state_t;

  rgw_state_t state_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] wdCtl_ff;
  logic [7:0] rtiCtl_ff;
  logic [2:0] intEn_ff;
  logic scm_ff;
  logic cmLatch_ff;
  logic wdLatch_ff;
  logic wakeByReset_ff;
  logic armed_ff;
  logic pinSample_ff;
  rgw_pkg::rgw_vec_t vec_ff;
  logic vecValid_ff;
  logic [7:0] rdData_ff;
  logic [5:0] checkCnt_ff;
  logic [rgw_pkg::WD_W-1:0] wdCnt_ff;
  logic [rgw_pkg::WD_W-1:0] rtiCnt_ff;
  logic lockPrev_ff;
  logic scmPrev_ff;

  logic seqLoad;
  logic [rgw_pkg::CNT_W-1:0] seqLoadVal;
  logic [rgw_pkg::CNT_W-1:0] seqCount;
  logic seqZero;
  logic clock_monitor_reset;
  logic wdReset;
  logic wdArmWr;
  logic wdPeriodEnd;
  logic wdEnabled;
  logic wdEarly;
  logic rtiEvt;
  logic anyReset;
  logic [2:0] flags;
  logic [2:0] clrWr;
  logic [rgw_pkg::WD_W-1:0] wdPeriod;
  logic checkDone;
  logic checkToPin;

  assign wdEnabled = (wdCtl_ff[2:0] != 3'h0);
  assign wdPeriod = rgw_pkg::WD_W'(16'h0100) << wdCtl_ff[2:0];
  assign wdArmWr = regWr && regAddr == rgw_pkg::ADDR_WDARM;
  // down counter: last quarter means count below a quarter of the period
  assign wdEarly = wdCtl_ff[rgw_pkg::WDCTL_WIN_BIT] && (wdCnt_ff >= (wdPeriod >> 2));
  assign wdPeriodEnd = wdEnabled && wdCnt_ff == '0;
  assign wdReset = wdEnabled && (wdPeriodEnd || (wdArmWr && (wdEarly
    || (regWrData != rgw_pkg::WD_KEY1 && regWrData != rgw_pkg::WD_KEY2)
    || (regWrData == rgw_pkg::WD_KEY2 && !armed_ff))));
  // clock monitor is ignored while stopped
  assign clockMonitorActive = ctrl_ff[rgw_pkg::CTRL_CME_BIT] && !clocksStopped;
  assign clock_monitor_reset = ctrl_ff[rgw_pkg::CTRL_CME_BIT] && statusIn.lossOfClock
    && !ctrl_ff[rgw_pkg::CTRL_SELF_CLOCK_ENABLE_BIT] && state_ff != ST_STOP;
  assign anyReset = !resetPinIn || statusIn.powerOn || statusIn.lowVoltage || wdReset || clock_monitor_reset;
  assign checkDone = statusIn.clockOk || checkCnt_ff == 6'(rgw_pkg::CHECK_WINDOWS - 1);
  // check ends in the pin-low phase: reset wake-up, or failed interrupt wake-up without self clock
  assign checkToPin = state_ff == ST_CHECK && checkDone
    && (wakeByReset_ff || (!statusIn.clockOk && !ctrl_ff[rgw_pkg::CTRL_SELF_CLOCK_ENABLE_BIT]));

  rgw_counter #(.W(rgw_pkg::CNT_W)) seqCnt (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .load(seqLoad),
    .loadVal(seqLoadVal),
    .run(1'b1),
    .count(seqCount),
    .zero(seqZero)
  );

  always_comb begin
    seqLoad = 1'b0;
    seqLoadVal = '0;
    // only a new reset from run reloads; a pin held low during the wait must not stretch it
    if (anyReset && state_ff == ST_RUN) begin
      seqLoad = 1'b1;
      seqLoadVal = rgw_pkg::CNT_W'(rgw_pkg::PIN_LOW_CYC + rgw_pkg::SYNC_EXTRA_CYC - 1);
    end else if (checkToPin) begin
      seqLoad = 1'b1;
      seqLoadVal = rgw_pkg::CNT_W'(rgw_pkg::PIN_LOW_CYC + rgw_pkg::SYNC_EXTRA_CYC - 1);
    end else if (state_ff == ST_PINLOW && seqZero) begin
      seqLoad = 1'b1;
      seqLoadVal = rgw_pkg::CNT_W'(rgw_pkg::SAMPLE_WAIT_CYC - 1);
    end
  end

  // sequencer; reset sources act on the very next edge, exit only counts on mclk
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff <= ST_CHECK;
      wakeByReset_ff <= 1'b1;
      checkCnt_ff <= 6'h00;
    end else begin
      case (state_ff)
        ST_RUN: begin
          if (anyReset) begin
            state_ff <= ST_PINLOW;
          end else if (stopReq && !ctrl_ff[rgw_pkg::CTRL_PSTOP_BIT]) begin
            state_ff <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (!resetPinIn) begin
            state_ff <= ST_CHECK;
            wakeByReset_ff <= 1'b1;
            checkCnt_ff <= 6'h00;
          end else if (wakeIrq) begin
            state_ff <= ST_CHECK;
            wakeByReset_ff <= 1'b0;
            checkCnt_ff <= 6'h00;
          end
        end
        ST_CHECK: begin
          if (checkDone) begin
            state_ff <= checkToPin ? ST_PINLOW : ST_RUN;
          end else begin
            checkCnt_ff <= checkCnt_ff + 6'h01;
          end
        end
        ST_PINLOW: begin
          if (seqZero) begin
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (seqZero) begin
            state_ff <= ST_HOLD;
          end
        end
        default: begin
          if (resetPinIn) begin
            state_ff <= ST_RUN;
          end
        end
      endcase
    end
  end

  assign resetPinOut = 1'b0;
  // pin stays released during the clock check so the drive lasts exactly the pin-low phase
  assign resetPinOe = (state_ff == ST_PINLOW);
  assign internalReset = state_ff != ST_RUN && state_ff != ST_STOP
    && !(state_ff == ST_CHECK && !wakeByReset_ff);
  assign clocksStopped = (state_ff == ST_STOP) || (state_ff == ST_CHECK && !wakeByReset_ff);

  // causes latched until the sequencer is back in run
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmLatch_ff <= 1'b0;
      wdLatch_ff <= 1'b0;
    end else if (clock_monitor_reset || (checkToPin && !wakeByReset_ff)) begin
      cmLatch_ff <= 1'b1;
    end else if (wdReset) begin
      wdLatch_ff <= 1'b1;
    end else if (state_ff == ST_RUN) begin
      cmLatch_ff <= 1'b0;
      wdLatch_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pinSample_ff <= 1'b0;
      vec_ff <= rgw_pkg::VEC_POR_EXT;
      vecValid_ff <= 1'b0;
    end else if (state_ff == ST_WAIT && seqZero) begin
      pinSample_ff <= resetPinIn;
      vecValid_ff <= 1'b1;
      if (!resetPinIn) begin
        vec_ff <= rgw_pkg::VEC_POR_EXT;
      end else if (cmLatch_ff) begin
        vec_ff <= rgw_pkg::VEC_CLKMON;
      end else if (wdLatch_ff) begin
        vec_ff <= rgw_pkg::VEC_WATCHDOG;
      end else begin
        vec_ff <= rgw_pkg::VEC_POR_EXT;
      end
    end else if (anyReset && state_ff == ST_RUN) begin
      vecValid_ff <= 1'b0;
    end
  end
  assign resetVector = vec_ff;
  assign vectorValid = vecValid_ff && state_ff == ST_RUN;

  // configuration; resets restore defaults, monitor reset forces both enables
  always_ff @(posedge mclk) begin
    if (sys_rst || (state_ff == ST_STOP && !resetPinIn) || (anyReset && state_ff == ST_RUN)) begin
      ctrl_ff <= rgw_pkg::CTRL_RESET;
      wdCtl_ff <= rgw_pkg::WDCTL_RESET;
      rtiCtl_ff <= rgw_pkg::RTICTL_RESET;
      intEn_ff <= rgw_pkg::INTEN_RESET;
    end else begin
      if (state_ff == ST_CHECK && !wakeByReset_ff) begin
        ctrl_ff[rgw_pkg::CTRL_PLL_CLOCK_SELECT_BIT] <= 1'b0;
      end else if (regWr && regAddr == rgw_pkg::ADDR_CTRL) begin
        ctrl_ff <= regWrData;
      end
      if (regWr && regAddr == rgw_pkg::ADDR_WDCTL) begin
        wdCtl_ff <= regWrData;
      end
      if (regWr && regAddr == rgw_pkg::ADDR_RTICTL) begin
        rtiCtl_ff <= regWrData;
      end
      if (regWr && regAddr == rgw_pkg::ADDR_INTEN) begin
        intEn_ff <= regWrData[2:0];
      end
    end
  end
  assign pllClockSelect = ctrl_ff[rgw_pkg::CTRL_PLL_CLOCK_SELECT_BIT] && !scm_ff;

  // self clock mode enters on failed checks or clock loss, leaves on good clock
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      scm_ff <= 1'b0;
    end else if (clock_monitor_reset) begin
      scm_ff <= 1'b1;
    end else if (ctrl_ff[rgw_pkg::CTRL_SELF_CLOCK_ENABLE_BIT]) begin
      if (statusIn.clockOk) begin
        scm_ff <= 1'b0;
      end else if (state_ff == ST_CHECK && checkCnt_ff == 6'(rgw_pkg::CHECK_WINDOWS - 1)) begin
        scm_ff <= 1'b1;
      end else if (statusIn.lossOfClock && ctrl_ff[rgw_pkg::CTRL_CME_BIT] && state_ff != ST_STOP) begin
        scm_ff <= 1'b1;
      end
    end
  end
  assign selfClockMode = scm_ff;

  // watchdog period counter and arm sequence
  always_ff @(posedge mclk) begin
    if (sys_rst || internalReset) begin
      wdCnt_ff <= wdPeriod;
      armed_ff <= 1'b0;
    end else if (regWr && regAddr == rgw_pkg::ADDR_WDCTL) begin
      // a rate write starts a full period at the new rate, also on first enable
      wdCnt_ff <= rgw_pkg::WD_W'(16'h0100) << regWrData[2:0];
      armed_ff <= 1'b0;
    end else if (!wdEnabled) begin
      wdCnt_ff <= wdPeriod;
      armed_ff <= 1'b0;
    end else if (wdArmWr && regWrData == rgw_pkg::WD_KEY1) begin
      armed_ff <= 1'b1;
      wdCnt_ff <= wdCnt_ff - 1'b1;
    end else if (wdArmWr && regWrData == rgw_pkg::WD_KEY2 && armed_ff) begin
      armed_ff <= 1'b0;
      wdCnt_ff <= wdPeriod;
    end else if (state_ff != ST_STOP && wdCnt_ff != '0) begin
      wdCnt_ff <= wdCnt_ff - 1'b1;
    end
  end

  // periodic counter runs outside stop; in stop only with the pseudo-stop and prescaler-run bits both set
  always_ff @(posedge mclk) begin
    if (sys_rst || rtiCtl_ff == 8'h00) begin
      rtiCnt_ff <= '0;
    end else if (state_ff != ST_STOP || (ctrl_ff[rgw_pkg::CTRL_PSTOP_BIT] && ctrl_ff[rgw_pkg::CTRL_PRE_BIT])) begin
      rtiCnt_ff <= rtiEvt ? '0 : rtiCnt_ff + 1'b1;
    end
  end
  assign rtiEvt = rtiCtl_ff != 8'h00 && rtiCnt_ff == {rtiCtl_ff, 8'hff};

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lockPrev_ff <= 1'b0;
      scmPrev_ff <= 1'b0;
    end else begin
      lockPrev_ff <= statusIn.pllLock;
      scmPrev_ff <= scm_ff;
    end
  end

  assign clrWr = (regWr && regAddr == rgw_pkg::ADDR_FLAGS) ? regWrData[2:0] : 3'h0;

  rgw_edge_flag rtiFlag (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .setEvt(rtiEvt),
    .clrWr(clrWr[2]),
    .enable(intEn_ff[2]),
    .flag(flags[2]),
    .irq(irqReq.periodic)
  );
  rgw_edge_flag lockFlag (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .setEvt(statusIn.pllLock != lockPrev_ff),
    .clrWr(clrWr[1]),
    .enable(intEn_ff[1]),
    .flag(flags[1]),
    .irq(irqReq.lock)
  );
  rgw_edge_flag scmFlag (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .setEvt(scm_ff != scmPrev_ff),
    .clrWr(clrWr[0]),
    .enable(intEn_ff[0]),
    .flag(flags[0]),
    .irq(irqReq.selfClock)
  );

  // read data are registered; unmapped addresses read zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdData_ff <= 8'h00;
    end else if (regRd) begin
      if (regAddr == rgw_pkg::ADDR_CTRL) begin
        rdData_ff <= ctrl_ff;
      end else if (regAddr == rgw_pkg::ADDR_INTEN) begin
        rdData_ff <= {5'h00, intEn_ff};
      end else if (regAddr == rgw_pkg::ADDR_FLAGS) begin
        rdData_ff <= {5'h00, flags};
      end else if (regAddr == rgw_pkg::ADDR_WDCTL) begin
        rdData_ff <= wdCtl_ff;
      end else if (regAddr == rgw_pkg::ADDR_RTICTL) begin
        rdData_ff <= rtiCtl_ff;
      end else if (regAddr == rgw_pkg::ADDR_STATUS) begin
        rdData_ff <= {3'h0, pinSample_ff, cmLatch_ff, wdLatch_ff, scm_ff, statusIn.pllLock};
      end else begin
        rdData_ff <= 8'h00;
      end
    end else begin
      rdData_ff <= 8'h00;
    end
  end
  assign regRdData = rdData_ff;
endmodule // rgw_reset_wakeup
`default_nettype wire

// ===== test/rgw_partner.sv
// partner: reset pin wiring with pull-up and an external hold-low source
`timescale 1ns/1ns
`default_nettype none
module rgw_partner (
  input wire logic mclk,
  input wire logic holdReq,
  input wire logic [9:0] holdLen,
  input wire logic resetPinOut,
  input wire logic resetPinOe,
  output logic resetPinIn
);
  logic [9:0] holdCnt_ff;
  initial holdCnt_ff = 10'h000;
  always @(posedge mclk) begin
    if (holdReq) holdCnt_ff <= holdLen;
    else if (holdCnt_ff != 10'h000) holdCnt_ff <= holdCnt_ff - 10'h001;
  end
  // wired pin: pull-up level unless the device or the outside pulls low
  assign resetPinIn = !(resetPinOe && !resetPinOut) && (holdCnt_ff == 10'h000);
endmodule // rgw_partner
`default_nettype wire

// ===== test/rgw_reset_wakeup_asserts.sv
// checker: timing relations of the reset pin, internal reset and wake-up
`timescale 1ns/1ns
`default_nettype none
module rgw_reset_wakeup_asserts (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic resetPinIn,
  input wire logic resetPinOut,
  input wire logic resetPinOe,
  input wire logic internalReset,
  input wire rgw_pkg::rgw_vec_t resetVector,
  input wire logic vectorValid,
  input wire logic clocksStopped,
  input wire logic selfClockMode,
  input wire logic pllClockSelect,
  input wire logic clockMonitorActive
);
  localparam int OE_CYC = rgw_pkg::PIN_LOW_CYC + rgw_pkg::SYNC_EXTRA_CYC;
  logic [7:0] oeCnt_ff;
  logic [15:0] postCnt_ff;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // counters measure pin drive length and the wait after release
  always_ff @(posedge mclk) begin
    if (sys_rst || !resetPinOe) oeCnt_ff <= 8'h00;
    else oeCnt_ff <= oeCnt_ff + 8'h01;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst || resetPinOe) postCnt_ff <= 16'h0000;
    else if (internalReset && postCnt_ff != 16'hffff) postCnt_ff <= postCnt_ff + 16'h0001;
  end
  property p_oe_low; resetPinOe |-> !resetPinOut; endproperty
  a_oe_low: assert property (p_oe_low) else $error("pin driven high");
  property p_oe_len; $fell(resetPinOe) |-> oeCnt_ff == OE_CYC; endproperty
  a_oe_len: assert property (p_oe_len) else $error("pin low time wrong");
  property p_oe_int; resetPinOe |-> internalReset; endproperty
  a_oe_int: assert property (p_oe_int) else $error("internal reset low while pin driven");
  property p_rel; $fell(internalReset) |-> resetPinIn && postCnt_ff >= 16'd64; endproperty
  a_rel: assert property (p_rel) else $error("internal reset released early");
  property p_bad_arm;
    regWr && regAddr == rgw_pkg::ADDR_WDARM && regWrData != rgw_pkg::WD_KEY1 &&
      regWrData != rgw_pkg::WD_KEY2 && !internalReset |-> ##[1:8] resetPinOe;
  endproperty
  a_bad_arm: assert property (p_bad_arm) else $error("bad arm value did not reset");
  property p_entry; !resetPinIn && !internalReset |-> ##[1:60] resetPinOe; endproperty
  a_entry: assert property (p_entry) else $error("pin low did not start reset");
  property p_cm_off; clocksStopped |-> !clockMonitorActive; endproperty
  a_cm_off: assert property (p_cm_off) else $error("monitor active in stop");
  property p_pll_wake; $fell(clocksStopped) |-> ##[0:1] !pllClockSelect; endproperty
  a_pll_wake: assert property (p_pll_wake) else $error("pll select kept after stop");
  property p_rd_idle; !$past(regRd) |-> regRdData == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  c_wd: cover property (vectorValid && resetVector == rgw_pkg::VEC_WATCHDOG);
  c_cm: cover property (vectorValid && resetVector == rgw_pkg::VEC_CLKMON);
  c_stop: cover property ($fell(clocksStopped));
  c_scm: cover property (selfClockMode);
endmodule // rgw_reset_wakeup_asserts
bind rgw_reset_wakeup rgw_reset_wakeup_asserts rgw_reset_wakeup_asserts_inst (.mclk(mclk), .sys_rst(sys_rst),
  .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .resetPinIn(resetPinIn), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .internalReset(internalReset),
  .resetVector(resetVector), .vectorValid(vectorValid), .clocksStopped(clocksStopped),
  .selfClockMode(selfClockMode), .pllClockSelect(pllClockSelect), .clockMonitorActive(clockMonitorActive));
`default_nettype wire

// ===== test/tb.sv
// testbench: reset, watchdog, monitor, flag and stop scenarios against a small model
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic mclk, sys_rst, regWr, regRd, stopReq, wakeIrq, holdReq, resetPinIn, resetPinOut, resetPinOe;
  logic internalReset, vectorValid, clocksStopped, selfClockMode, pllClockSelect, clockMonitorActive;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData, rd;
  logic [9:0] holdLen;
  rgw_pkg::rgw_status_in_t statusIn;
  rgw_pkg::rgw_vec_t resetVector;
  rgw_pkg::rgw_irq_t irqReq;
  int fail_count, checked, n, seqLen, oeCycles, n0;
  rgw_reset_wakeup rgw_reset_wakeup_inst (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .statusIn(statusIn),
    .stopReq(stopReq), .wakeIrq(wakeIrq), .resetPinIn(resetPinIn), .resetPinOut(resetPinOut),
    .resetPinOe(resetPinOe), .internalReset(internalReset), .resetVector(resetVector),
    .vectorValid(vectorValid), .clocksStopped(clocksStopped), .selfClockMode(selfClockMode),
    .pllClockSelect(pllClockSelect), .clockMonitorActive(clockMonitorActive), .irqReq(irqReq));
  rgw_partner rgw_partner_inst (.mclk(mclk), .holdReq(holdReq), .holdLen(holdLen),
    .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .resetPinIn(resetPinIn));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) if (resetPinOe === 1'b1) oeCycles++;
  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge mclk);
    regWr <= 1'b1; regAddr <= a; regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rdr(logic [3:0] a);
    @(posedge mclk);
    regRd <= 1'b1; regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 rd = regRdData;
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  // model of vector choice from sampled pin and pending causes
  function automatic rgw_pkg::rgw_vec_t expVec(bit pinLow, bit cm, bit wd);
    if (pinLow) return rgw_pkg::VEC_POR_EXT;
    if (cm) return rgw_pkg::VEC_CLKMON;
    return wd ? rgw_pkg::VEC_WATCHDOG : rgw_pkg::VEC_POR_EXT;
  endfunction
  task automatic seq(rgw_pkg::rgw_vec_t exp);
    // settle first so a reset launched on this very edge is seen at once
    #1;
    n = 0;
    while (resetPinOe !== 1'b1 && n < 4000) begin tick(1); n++; end
    n = 0;
    while (resetPinOe === 1'b1 && n < 400) begin tick(1); n++; end
    chk("pin low cycles", 8'(n), 8'(rgw_pkg::PIN_LOW_CYC + rgw_pkg::SYNC_EXTRA_CYC));
    while (internalReset !== 1'b0 && n < 4000) begin tick(1); n++; end
    seqLen = n;
    chk("sequence length ok", 8'(seqLen >= rgw_pkg::SEQ_CYC), 8'h01);
    chk("vector", 8'(resetVector), 8'(exp));
    chk("reset released", 8'(internalReset), 8'h00);
    chk("vector valid", 8'(vectorValid), 8'h01);
    wr(rgw_pkg::ADDR_FLAGS, 8'h07);
  endtask
  initial begin
    regWr = 0; regRd = 0; regAddr = 0; regWrData = 0; stopReq = 0; wakeIrq = 0; holdReq = 0; holdLen = 0;
    statusIn = '0; statusIn.clockOk = 1'b1; sys_rst = 1; fail_count = 0; checked = 0; oeCycles = 0;
    void'($urandom(32'hfd4fe8ce));
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    seq(expVec(0, 0, 0));
    rdr(rgw_pkg::ADDR_CTRL); chk("ctrl default", rd, rgw_pkg::CTRL_RESET);
    wr(4'hf, 8'($urandom)); rdr(4'hf); chk("unmapped", rd, 8'h00);
    wr(rgw_pkg::ADDR_WDCTL, 8'h01); n0 = oeCycles;
    repeat (3) begin
      tick(100 + $urandom % 200);
      wr(rgw_pkg::ADDR_WDARM, rgw_pkg::WD_KEY1); wr(rgw_pkg::ADDR_WDARM, rgw_pkg::WD_KEY2);
    end
    chk("armed no reset", 8'(oeCycles - n0), 8'h00);
    seq(expVec(0, 0, 1));
    for (int i = 1; i >= 0; i--) begin
      wr(rgw_pkg::ADDR_WDCTL, 8'h01); wr(rgw_pkg::ADDR_WDARM, i ? 8'h12 : rgw_pkg::WD_KEY2);
      seq(expVec(0, 0, 1));
    end
    wr(rgw_pkg::ADDR_WDCTL, 8'h81); wr(rgw_pkg::ADDR_WDARM, rgw_pkg::WD_KEY1);
    seq(expVec(0, 0, 1));
    wr(rgw_pkg::ADDR_CTRL, 8'h02); statusIn.lossOfClock <= 1'b1; tick(1); statusIn.lossOfClock <= 1'b0;
    seq(expVec(0, 1, 0));
    rdr(rgw_pkg::ADDR_CTRL); chk("monitor bits", rd & 8'h06, 8'h06);
    n0 = oeCycles; statusIn.clockOk <= 1'b0; statusIn.lossOfClock <= 1'b1; tick(60);
    chk("self clock", 8'(selfClockMode), 8'h01);
    chk("no monitor reset", 8'(oeCycles - n0), 8'h00);
    rdr(rgw_pkg::ADDR_FLAGS); chk("scm flag", rd & 8'h01, 8'h01);
    statusIn.clockOk <= 1'b1; statusIn.lossOfClock <= 1'b0; tick(60); wr(rgw_pkg::ADDR_FLAGS, 8'h07);
    statusIn.pllLock <= 1'b1; tick(4);
    rdr(rgw_pkg::ADDR_FLAGS); chk("lock flag", rd & 8'h02, 8'h02);
    wr(rgw_pkg::ADDR_INTEN, 8'h02); tick(1); chk("lock irq", 8'(irqReq.lock), 8'h01);
    wr(rgw_pkg::ADDR_FLAGS, 8'h02); tick(1); chk("lock irq clr", 8'(irqReq.lock), 8'h00);
    // rate 1 gives a period of 512 cycles
    wr(rgw_pkg::ADDR_RTICTL, 8'h01); wr(rgw_pkg::ADDR_INTEN, 8'h04); tick(500);
    rdr(rgw_pkg::ADDR_FLAGS); chk("periodic early", rd & 8'h04, 8'h00);
    tick(20); chk("periodic irq", 8'(irqReq.periodic), 8'h01);
    wr(rgw_pkg::ADDR_RTICTL, 8'h00);
    wr(rgw_pkg::ADDR_CTRL, 8'h07); stopReq <= 1'b1; tick(4);
    chk("stopped", 8'(clocksStopped), 8'h01);
    chk("monitor off", 8'(clockMonitorActive), 8'h00);
    stopReq <= 1'b0; wakeIrq <= 1'b1; n = 0;
    while (clocksStopped !== 1'b0 && n < 200) begin tick(1); n++; end
    wakeIrq <= 1'b0;
    chk("woken", 8'(clocksStopped), 8'h00);
    chk("pll select cleared", 8'(pllClockSelect), 8'h00);
    chk("monitor on", 8'(clockMonitorActive), 8'h01);
    @(posedge mclk); holdLen <= 10'(300 + $urandom % 100); holdReq <= 1'b1;
    @(posedge mclk); holdReq <= 1'b0;
    seq(expVec(1, 0, 0));
    chk("held past release", 8'(seqLen >= int'(holdLen)), 8'h01);
    stop_test();
  end
  initial begin
    #400000;
    fail_count++;
    stop_test();
  end
endmodule // tb
`default_nettype wire
